/* File: logic/disk_cmd_pkg.sv */
package disk_cmd_pkg;
  localparam int WORD_W = 16;
  // control block return word indices
  localparam logic [3:0] CB_STATUS_IDX = 4'hb;
  localparam logic [3:0] CB_ERROR_IDX  = 4'he;
  localparam logic [3:0] CB_UNIT_IDX   = 4'hf;
  // control block status word bits
  localparam int ST_HARD     = 0;
  localparam int ST_INTERP   = 1;
  localparam int ST_SOFT     = 2;
  localparam int ST_ECC_FIX  = 4;
  localparam int ST_ECC_FAIL = 5;
  localparam int ST_RELOC    = 6;
  localparam int ST_DONE     = 15;
  // control block error word bits
  localparam int ER_IFACE    = 1;
  localparam int ER_DRIVE    = 5;
  localparam int ER_CH_TMO   = 6;
  localparam int ER_END_ADDR = 7;
  localparam int ER_VERIFY   = 11;
  localparam int ER_CHAN     = 12;
  localparam int ER_ECC      = 14;
  localparam int ER_HDR      = 15;
  // unit status word bits
  localparam int US_READY    = 2;
  localparam int US_UNIT_LO  = 6;
  // programmed-command error register bits
  localparam int PE_END_ADDR = 7;
  localparam int PE_CHAN     = 12;
  // completion and command status register layouts
  localparam int CODE_LSB    = 6;
  localparam int SYNC_FLAG   = 5;
  localparam int CS_BUSY     = 0;
  localparam int CS_LIST     = 1;
  // asynchronous codes, octal value in the comment
  localparam logic [9:0] CODE_NULL       = 10'h000; // 0
  localparam logic [9:0] CODE_SOFT       = 10'h002; // 2
  localparam logic [9:0] CODE_HARD       = 10'h003; // 3
  localparam logic [9:0] CODE_IBIT       = 10'h004; // 4
  localparam logic [9:0] CODE_CLEAN      = 10'h005; // 5
  localparam logic [9:0] CODE_SBIT       = 10'h007; // 7
  localparam logic [9:0] CODE_NOT_ZERO   = 10'h008; // 10
  localparam logic [9:0] CODE_ILLEGAL    = 10'h009; // 11
  localparam logic [9:0] CODE_BAD_PAGE   = 10'h00d; // 15
  localparam logic [9:0] CODE_BAD_XFER   = 10'h00e; // 16
  localparam logic [9:0] CODE_UNWRITABLE = 10'h010; // 20
  localparam logic [9:0] CODE_UNREADABLE = 10'h011; // 21
  // programmed commands
  localparam logic [3:0] PIO_SYSGEN      = 4'h0;
  localparam logic [3:0] PIO_EXT_STATUS  = 4'h1;
  localparam logic [3:0] PIO_START       = 4'h2;
  localparam logic [3:0] PIO_START_HP    = 4'h3;
  localparam logic [3:0] PIO_CANCEL      = 4'h4;
  localparam logic [3:0] PIO_CANCEL_HP   = 4'h5;
  localparam logic [3:0] PIO_GET         = 4'h6;
  localparam logic [3:0] PIO_SET         = 4'h7;
  localparam logic [3:0] PIO_PLOAD       = 4'h8;
  localparam logic [3:0] PIO_RESET       = 4'h9;
  // block commands
  localparam logic [3:0] CB_READ         = 4'h0;
  localparam logic [3:0] CB_READ_VERIFY  = 4'h1;
  localparam logic [3:0] CB_READ_RAW     = 4'h2;
  localparam logic [3:0] CB_READ_HEADERS = 4'h3;
  localparam logic [3:0] CB_WRITE        = 4'h4;
  localparam logic [3:0] CB_WRITE_VERIFY = 4'h5;
  localparam logic [3:0] CB_WRITE_VER_SW = 4'h6;
  // microcode revision returned to software
  localparam logic [15:0] UCODE_REV_HI   = 16'h0001;
  localparam logic [15:0] UCODE_REV_LO   = 16'h0000;
endpackage

/* File: logic/cb_writeback.sv */
`timescale 1ns/100ps
`default_nettype none
module cb_writeback
  import disk_cmd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic [15:0] status_in,
  input  wire logic [15:0] error_in,
  input  wire logic [15:0] unit_in,
  input  wire logic        mem_ready_in,
  input  wire logic        mem_error_in,
  output logic             mem_valid_out,
  output logic [3:0]       mem_index_out,
  output logic [15:0]      mem_data_out,
  output logic             done_out,
  output logic             fail_out
);
  logic [1:0]  step_q;
  logic [15:0] st_q;
  logic [15:0] er_q;
  logic [15:0] un_q;
  logic        acc;

  assign acc = mem_valid_out && mem_ready_in;

  // status word goes last and alone carries done, so no partial view
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_valid_out <= 1'b0;
      step_q        <= 2'h0;
      mem_index_out <= 4'h0;
      mem_data_out  <= 16'h0000;
      st_q          <= 16'h0000;
      er_q          <= 16'h0000;
      un_q          <= 16'h0000;
    end else if (start_in) begin
      mem_valid_out <= 1'b1;
      step_q        <= 2'h0;
      st_q          <= status_in | (16'h0001 << ST_DONE);
      er_q          <= error_in;
      un_q          <= unit_in;
      mem_index_out <= CB_ERROR_IDX;
      mem_data_out  <= error_in;
    end else if (acc) begin
      step_q <= step_q + 2'h1;
      if (mem_error_in || step_q == 2'h2) begin
        mem_valid_out <= 1'b0;
      end else if (step_q == 2'h0) begin
        mem_index_out <= CB_UNIT_IDX;
        mem_data_out  <= un_q;
      end else begin
        mem_index_out <= CB_STATUS_IDX;
        mem_data_out  <= st_q;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      done_out <= acc && (mem_error_in || step_q == 2'h2);
      fail_out <= acc && mem_error_in;
    end
  end

  sequence unit_taken_s;
    acc && !mem_error_in && mem_index_out == CB_UNIT_IDX;
  endsequence
  sequence status_offered_s;
    mem_valid_out && mem_index_out == CB_STATUS_IDX && mem_data_out[ST_DONE];
  endsequence
  property done_after_unit_p;
    @(posedge clk_in) disable iff (rst_in)
      unit_taken_s |=> status_offered_s;
  endproperty
  done_order_a: assert property (done_after_unit_p)
    else $error("status word did not follow unit word");
  first_word_a: assert property (@(posedge clk_in) disable iff (rst_in)
    start_in |=> mem_valid_out && mem_index_out == CB_ERROR_IDX)
    else $error("writeback did not open with error word");
endmodule
`default_nettype wire

/* File: logic/disk_cmd_status.sv */
// Operation
// - ext status unit 0 returns revision; sysgen nop
// - ext status 1-3, hp cancel nop; hp start
// - verify reads nop, raw/headers illegal, verify-write writes
// - async interrupt on list done, request-flagged block done or error
// - sync interrupt per programmed command when enabled
// - sync outranks async and replaces its status
// - async code sits in completion bits 6-15
// - async codes 0,2,3,4,5,7 as defined
// - codes 10,11,20 plus unreadable, page, transfer
// - failed get/set/load sets bit 7 or 12
// - write words 11, 14, 15 into block
// - block status bits 0,1,2,4,5,6, done on top
// - block error bits 1,5,6,7,11,12,14,15
// - interface fault from any listed cause
// - drive error from any listed cause
// - unit word: ready bit 2, unit 6-7
// - status shows state, list started, completion, code
`timescale 1ns/100ps
`default_nettype none
module disk_cmd_status
  import disk_cmd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        pio_valid_in,
  input  wire logic [3:0]  pio_cmd_in,
  input  wire logic [1:0]  pio_unit_in,
  input  wire logic        pio_fail_in,
  input  wire logic        pio_end_addr_err_in,
  input  wire logic        pio_chan_err_in,
  input  wire logic        sync_int_enable_in,
  input  wire logic        irq_ack_in,
  input  wire logic        cb_valid_in,
  output logic             cb_ready_out,
  input  wire logic [3:0]  cb_cmd_in,
  input  wire logic [1:0]  cb_unit_in,
  input  wire logic [15:0] cb_entry_status_in,
  input  wire logic        cb_last_in,
  input  wire logic        cb_ibit_in,
  input  wire logic        cb_sbit_in,
  input  wire logic        cb_unreadable_in,
  input  wire logic        cb_bad_page_in,
  input  wire logic        cb_bad_xfer_in,
  output logic             exec_start_out,
  output logic             exec_write_out,
  input  wire logic        exec_done_in,
  input  wire logic        exec_hard_in,
  input  wire logic        exec_soft_in,
  input  wire logic        exec_ecc_fixed_in,
  input  wire logic        exec_ecc_failed_in,
  input  wire logic        exec_relocated_in,
  input  wire logic [5:0]  iface_cause_in,
  input  wire logic [5:0]  drive_cause_in,
  input  wire logic        chan_timeout_in,
  input  wire logic        end_addr_err_in,
  input  wire logic        verify_err_in,
  input  wire logic        chan_err_in,
  input  wire logic        ecc_detected_in,
  input  wire logic        header_err_in,
  input  wire logic        drive_ready_in,
  output logic             mem_valid_out,
  input  wire logic        mem_ready_in,
  input  wire logic        mem_error_in,
  output logic [3:0]       mem_index_out,
  output logic [15:0]      mem_data_out,
  output logic [15:0]      data_in_first_register_out,
  output logic [15:0]      data_in_second_register_out,
  output logic [15:0]      pio_error_status_out,
  output logic [15:0]      completion_status_out,
  output logic [15:0]      command_status_out,
  output logic             sync_irq_out,
  output logic             async_irq_out
);
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_WB} state_e;

  state_e      state_q;
  logic        list_q;
  logic [1:0]  unit_q;
  logic        last_q;
  logic        ibit_q;
  logic        sbit_q;
  logic        abort_q;
  logic [9:0]  code_q;
  logic [15:0] status_q;
  logic [15:0] error_q;
  logic        wb_start_q;
  logic        wb_done;
  logic        wb_fail;
  logic        sync_pend_q;
  logic        async_pend_q;
  logic [9:0]  async_code_q;
  logic [15:0] sync_word_q;
  logic [15:0] unit_word;
  logic        cb_take;
  logic        interp;
  logic [9:0]  interp_code;
  logic        fin;
  logic [9:0]  fin_code;
  logic        fin_abort;
  logic        async_evt;
  logic        sync_evt;

  // 0 read, 1 write, 2 no-op, 3 illegal
  function automatic logic [1:0] cb_class(input logic [3:0] cmd);
    case (cmd)
      CB_READ_VERIFY, CB_WRITE_VER_SW: cb_class = 2'h2;
      CB_READ_RAW, CB_READ_HEADERS:    cb_class = 2'h3;
      CB_WRITE, CB_WRITE_VERIFY:       cb_class = 2'h1;
      default:                         cb_class = 2'h0;
    endcase
  endfunction

  // mid-list blocks without the request flag stay silent
  function automatic logic [9:0] clean_code(input logic ib, input logic ls);
    if (ib) begin
      clean_code = CODE_IBIT;
    end else if (ls) begin
      clean_code = CODE_CLEAN;
    end else begin
      clean_code = CODE_NULL;
    end
  endfunction

  assign cb_ready_out = (state_q == S_IDLE) && list_q;
  assign cb_take      = cb_valid_in && cb_ready_out;
  assign sync_evt     = pio_valid_in && sync_int_enable_in;

  always_comb begin
    interp      = 1'b1;
    interp_code = CODE_NULL;
    if (cb_entry_status_in != 16'h0000) begin
      interp_code = CODE_NOT_ZERO;
    end else if (cb_class(cb_cmd_in) == 2'h3) begin
      interp_code = CODE_ILLEGAL;
    end else if (cb_bad_page_in) begin
      interp_code = CODE_BAD_PAGE;
    end else if (cb_bad_xfer_in) begin
      interp_code = CODE_BAD_XFER;
    end else begin
      interp = 1'b0;
    end
  end

  // an unreadable block cannot take status, so it finishes at once
  always_comb begin
    fin       = wb_done;
    fin_code  = wb_fail ? CODE_UNWRITABLE : code_q;
    fin_abort = wb_fail || abort_q;
    if (cb_take && cb_unreadable_in) begin
      fin       = 1'b1;
      fin_code  = CODE_UNREADABLE;
      fin_abort = 1'b1;
    end
  end
  assign async_evt = fin && (fin_code != CODE_NULL);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= S_IDLE;
      wb_start_q <= 1'b0;
    end else begin
      wb_start_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cb_take && !cb_unreadable_in) begin
            if (interp || cb_class(cb_cmd_in) == 2'h2) begin
              state_q    <= S_WB;
              wb_start_q <= 1'b1;
            end else begin
              state_q <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          if (exec_done_in) begin
            state_q    <= S_WB;
            wb_start_q <= 1'b1;
          end
        end
        S_WB: begin
          if (wb_done) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      exec_start_out <= 1'b0;
      exec_write_out <= 1'b0;
    end else begin
      exec_start_out <= cb_take && !cb_unreadable_in && !interp &&
                        (cb_class(cb_cmd_in) <= 2'h1);
      if (cb_take) begin
        exec_write_out <= cb_class(cb_cmd_in) == 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      unit_q   <= 2'h0;
      last_q   <= 1'b0;
      ibit_q   <= 1'b0;
      sbit_q   <= 1'b0;
      abort_q  <= 1'b0;
      code_q   <= CODE_NULL;
      status_q <= 16'h0000;
      error_q  <= 16'h0000;
    end else if (cb_take) begin
      unit_q   <= cb_unit_in;
      last_q   <= cb_last_in;
      ibit_q   <= cb_ibit_in;
      sbit_q   <= cb_sbit_in;
      abort_q  <= interp;
      code_q   <= interp ? interp_code : clean_code(cb_ibit_in, cb_last_in);
      status_q <= interp ? (16'h0001 << ST_INTERP) : 16'h0000;
      error_q  <= 16'h0000;
    end else if (state_q == S_EXEC && exec_done_in) begin
      status_q <= (16'(exec_hard_in)       << ST_HARD)
                | (16'(exec_soft_in)       << ST_SOFT)
                | (16'(exec_ecc_fixed_in)  << ST_ECC_FIX)
                | (16'(exec_ecc_failed_in) << ST_ECC_FAIL)
                | (16'(exec_relocated_in)  << ST_RELOC);
      error_q  <= (16'(|iface_cause_in)    << ER_IFACE)
                | (16'(|drive_cause_in)    << ER_DRIVE)
                | (16'(chan_timeout_in)    << ER_CH_TMO)
                | (16'(end_addr_err_in)    << ER_END_ADDR)
                | (16'(verify_err_in)      << ER_VERIFY)
                | (16'(chan_err_in)        << ER_CHAN)
                | (16'(ecc_detected_in)    << ER_ECC)
                | (16'(header_err_in)      << ER_HDR);
      if (exec_hard_in) begin
        code_q  <= CODE_HARD;
        abort_q <= 1'b1;
      end else if (exec_soft_in && sbit_q) begin
        code_q  <= CODE_SBIT;
        abort_q <= 1'b1;
      end else if (exec_soft_in) begin
        code_q <= CODE_SOFT;
      end else begin
        code_q <= clean_code(ibit_q, last_q);
      end
    end
  end

  assign unit_word = (16'(unit_q) << US_UNIT_LO)
                   | (16'(drive_ready_in) << US_READY);

  cb_writeback u_wb (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .start_in      (wb_start_q),
    .status_in     (status_q),
    .error_in      (error_q),
    .unit_in       (unit_word),
    .mem_ready_in  (mem_ready_in),
    .mem_error_in  (mem_error_in),
    .mem_valid_out (mem_valid_out),
    .mem_index_out (mem_index_out),
    .mem_data_out  (mem_data_out),
    .done_out      (wb_done),
    .fail_out      (wb_fail)
  );

  // a start in the same cycle as a list end keeps the list running
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      list_q <= 1'b0;
    end else if (pio_valid_in && (pio_cmd_in == PIO_START ||
                                  pio_cmd_in == PIO_START_HP)) begin
      list_q <= 1'b1;
    end else if (pio_valid_in && (pio_cmd_in == PIO_CANCEL ||
                                  pio_cmd_in == PIO_RESET)) begin
      list_q <= 1'b0;
    end else if (fin && (fin_abort || last_q)) begin
      list_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_in_first_register_out  <= 16'h0000;
      data_in_second_register_out <= 16'h0000;
    end else if (pio_valid_in && pio_cmd_in == PIO_EXT_STATUS &&
                 pio_unit_in == 2'h0) begin
      data_in_first_register_out  <= UCODE_REV_HI;
      data_in_second_register_out <= UCODE_REV_LO;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pio_error_status_out <= 16'h0000;
    end else if (pio_valid_in && (pio_cmd_in == PIO_GET ||
                 pio_cmd_in == PIO_SET || pio_cmd_in == PIO_PLOAD)) begin
      pio_error_status_out <= pio_fail_in ?
        ((16'(pio_end_addr_err_in) << PE_END_ADDR) |
         (16'(pio_chan_err_in) << PE_CHAN)) : 16'h0000;
    end
  end

  // software must read completion before the next command overwrites it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_pend_q <= 1'b0;
      sync_word_q <= 16'h0000;
    end else if (sync_evt) begin
      sync_pend_q <= 1'b1;
      sync_word_q <= (16'h0001 << SYNC_FLAG) | 16'(pio_cmd_in);
    end else if (irq_ack_in) begin
      sync_pend_q <= 1'b0;
    end
  end

  // a fresh async event survives a same-cycle sync; older info is replaced
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      async_pend_q <= 1'b0;
      async_code_q <= CODE_NULL;
    end else if (async_evt) begin
      async_pend_q <= 1'b1;
      async_code_q <= fin_code;
    end else if (sync_evt) begin
      async_pend_q <= 1'b0;
      async_code_q <= CODE_NULL;
    end else if (irq_ack_in && !sync_pend_q) begin
      async_pend_q <= 1'b0;
    end
  end

  assign sync_irq_out  = sync_pend_q;
  assign async_irq_out = async_pend_q && !sync_pend_q;
  assign completion_status_out = sync_pend_q ? sync_word_q :
    {async_code_q, 6'h00};
  assign command_status_out = (16'(state_q != S_IDLE) << CS_BUSY)
                            | (16'(list_q) << CS_LIST);

  default clocking dflt_clk @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence clean_take_s;
    cb_take && !cb_unreadable_in && cb_entry_status_in == 16'h0000 &&
    !cb_bad_page_in && !cb_bad_xfer_in;
  endsequence

  ext_rev_a: assert property (pio_valid_in && pio_cmd_in == PIO_EXT_STATUS
    && pio_unit_in == 2'h0 |=> data_in_first_register_out == UCODE_REV_HI
    && data_in_second_register_out == UCODE_REV_LO)
    else $error("revision not returned");
  ext_nop_a: assert property (pio_valid_in && pio_cmd_in == PIO_EXT_STATUS
    && pio_unit_in != 2'h0 |=> $stable(data_in_first_register_out))
    else $error("ext status for unit 1-3 not a nop");
  hp_start_a: assert property (pio_valid_in && pio_cmd_in == PIO_START_HP
    |=> command_status_out[CS_LIST])
    else $error("high priority start did not start list");
  cb_illegal_a: assert property (clean_take_s and
    (cb_cmd_in == CB_READ_RAW) |=> code_q == CODE_ILLEGAL
    && state_q == S_WB && !exec_start_out)
    else $error("raw read not rejected");
  verify_write_a: assert property (clean_take_s and
    (cb_cmd_in == CB_WRITE_VERIFY) |=> exec_start_out
    && exec_write_out)
    else $error("verify write not run as write");
  async_done_a: assert property (wb_done && !wb_fail && last_q
    && !ibit_q && code_q == CODE_CLEAN
    |=> async_pend_q && async_code_q == CODE_CLEAN)
    else $error("list end raised no async interrupt");
  sync_irq_a: assert property (pio_valid_in && sync_int_enable_in
    |=> sync_irq_out && completion_status_out[SYNC_FLAG])
    else $error("sync interrupt missing");
  sync_prio_a: assert property (sync_irq_out |-> !async_irq_out)
    else $error("async shown over sync");
  code_field_a: assert property (async_irq_out |->
    completion_status_out[CODE_LSB-1:0] == 6'h00
    && completion_status_out[15:CODE_LSB] == async_code_q)
    else $error("async code misplaced");
  pio_err_a: assert property (pio_valid_in && pio_cmd_in == PIO_GET
    && pio_fail_in |=> (pio_error_status_out
    & ~((16'h0001 << PE_END_ADDR) | (16'h0001 << PE_CHAN))) == 16'h0000)
    else $error("stray error register bit");
endmodule
`default_nettype wire

/* File: sim/host_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_mem_model
  import disk_cmd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        exec_start_in,
  input  wire logic        mem_valid_in,
  input  wire logic [3:0]  mem_index_in,
  input  wire logic [15:0] mem_data_in,
  input  wire logic [1:0]  wait_in,
  output logic             exec_done_out,
  output logic             mem_ready_out,
  output logic [15:0]      status_out,
  output logic [15:0]      error_out,
  output logic [15:0]      unit_out,
  output logic             order_ok_out
);
  logic [2:0] run_q;
  logic [1:0] cnt_q;
  logic [1:0] seen_q;
  assign exec_done_out = run_q[2];
  // fixed three-cycle drive run
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      run_q <= '0;
    else
      run_q <= {run_q[1:0], exec_start_in};
  end
  // memory holds off wait_in+1 cycles before each accept
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 2'h0;
      mem_ready_out <= 1'h0;
    end else if (!mem_valid_in || mem_ready_out) begin
      cnt_q <= 2'h0;
      mem_ready_out <= 1'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      mem_ready_out <= (cnt_q == wait_in);
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_out <= 16'h0;
      error_out <= 16'h0;
      unit_out <= 16'h0;
      seen_q <= 2'h0;
      order_ok_out <= 1'h0;
    end else if (mem_valid_in && mem_ready_out) begin
      case (mem_index_in)
        CB_ERROR_IDX: begin
          error_out <= mem_data_in;
          seen_q[0] <= 1'h1;
        end
        CB_UNIT_IDX: begin
          unit_out <= mem_data_in;
          seen_q[1] <= 1'h1;
        end
        CB_STATUS_IDX: begin
          status_out <= mem_data_in;
          order_ok_out <= &seen_q;
          seen_q <= 2'h0;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: sim/disk_cmd_status_test.sv */
`timescale 1ns/100ps
`default_nettype none
module disk_cmd_status_test
  import disk_cmd_pkg::*;
;
  logic clk_in = 1'h0, rst_in = 1'h1, err_all = '0, ord_ok;
  logic pio_valid_in = '0, pio_fail_in = '0, sync_int_enable_in = '0;
  logic irq_ack_in = '0, cb_valid_in = '0, cb_last_in = '0, cb_ibit_in = '0;
  logic cb_sbit_in = '0, cb_unreadable_in = '0, cb_bad_page_in = '0;
  logic exec_hard_in = '0, drive_ready_in = '0, mem_error_in = '0;
  logic [3:0] pio_cmd_in = '0, cb_cmd_in = '0, mem_index_out;
  logic [1:0] pio_unit_in = '0, cb_unit_in = '0, wait_q = '0;
  logic [15:0] cb_entry_status_in = '0, cb_stat, cb_err, cb_unit;
  logic exec_done_in, mem_ready_in, cb_ready_out, exec_start_out;
  logic exec_write_out, mem_valid_out, sync_irq_out, async_irq_out;
  logic [15:0] mem_data_out, data_in_first_register_out;
  logic [15:0] data_in_second_register_out, pio_error_status_out;
  logic [15:0] completion_status_out, command_status_out;
  int n_errors = 0, cmp_count = 0;
  disk_cmd_status i_disk_cmd_status (
    .clk_in, .rst_in, .pio_valid_in, .pio_cmd_in, .pio_unit_in, .pio_fail_in,
    .pio_end_addr_err_in(pio_fail_in), .pio_chan_err_in(pio_fail_in),
    .sync_int_enable_in, .irq_ack_in, .cb_valid_in, .cb_ready_out,
    .cb_cmd_in, .cb_unit_in, .cb_entry_status_in, .cb_last_in, .cb_ibit_in,
    .cb_sbit_in, .cb_unreadable_in, .cb_bad_page_in,
    .cb_bad_xfer_in(cb_bad_page_in), .exec_start_out, .exec_write_out,
    .exec_done_in, .exec_hard_in, .exec_soft_in(err_all),
    .exec_ecc_fixed_in(err_all), .exec_ecc_failed_in(err_all),
    .exec_relocated_in(err_all), .iface_cause_in({3'h0, err_all, 2'h0}),
    .drive_cause_in({err_all, 5'h0}), .chan_timeout_in(err_all),
    .end_addr_err_in(err_all), .verify_err_in(err_all),
    .chan_err_in(err_all), .ecc_detected_in(err_all),
    .header_err_in(err_all), .drive_ready_in, .mem_valid_out, .mem_ready_in,
    .mem_error_in, .mem_index_out, .mem_data_out, .data_in_first_register_out,
    .data_in_second_register_out, .pio_error_status_out,
    .completion_status_out, .command_status_out, .sync_irq_out, .async_irq_out
  );
  host_mem_model i_host_mem_model (
    .clk_in, .rst_in, .exec_start_in(exec_start_out),
    .mem_valid_in(mem_valid_out), .mem_index_in(mem_index_out),
    .mem_data_in(mem_data_out), .wait_in(wait_q),
    .exec_done_out(exec_done_in), .mem_ready_out(mem_ready_in),
    .status_out(cb_stat), .error_out(cb_err), .unit_out(cb_unit),
    .order_ok_out(ord_ok)
  );
  initial forever #2.5 clk_in = ~clk_in;
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pio(input logic [3:0] cmd, input logic fail);
    @(posedge clk_in);
    pio_valid_in <= 1'h1;
    pio_cmd_in <= cmd;
    pio_fail_in <= fail;
    @(posedge clk_in);
    pio_valid_in <= 1'h0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic ack();
    @(posedge clk_in);
    irq_ack_in <= 1'h1;
    @(posedge clk_in);
    irq_ack_in <= 1'h0;
  endtask
  // both waits are bounded; a hang ends the run as a failure
  task automatic block(input logic [3:0] cmd, input logic [15:0] entry);
    bit ok;
    bit got;
    ok = 0;
    got = 0;
    @(posedge clk_in);
    cb_valid_in <= 1'h1;
    cb_cmd_in <= cmd;
    cb_entry_status_in <= entry;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(negedge clk_in);
      ok = (cb_ready_out === 1'h1);
    end
    @(posedge clk_in);
    cb_valid_in <= 1'h0;
    for (int i = 0; i < 200 && ok && !got; i++) begin
      @(negedge clk_in);
      got = (async_irq_out === 1'h1);
    end
    if (!got) begin
      n_errors++;
      results();
    end
  endtask
  task automatic t_pio();
    sync_int_enable_in <= 1'h1;
    pio(PIO_EXT_STATUS, 1'h0);
    check("first", data_in_first_register_out, UCODE_REV_HI);
    check("second", data_in_second_register_out, UCODE_REV_LO);
    check("sync", sync_irq_out, 1'h1);
    check("sync info", {completion_status_out[5],
                        completion_status_out[3:0]}, 5'h11);
    ack();
    sync_int_enable_in <= 1'h0;
    pio(PIO_SYSGEN, 1'h0);
    check("sync off", sync_irq_out, 1'h0);
    pio(PIO_GET, 1'h1);
    check("error reg", pio_error_status_out, 16'h1080);
    pio(PIO_SET, 1'h0);
    check("error clear", pio_error_status_out, 16'h0);
    $display("test programmed commands done");
  endtask
  task automatic t_exec();
    pio(PIO_START_HP, 1'h0);
    check("list", command_status_out[CS_LIST], 1'h1);
    wait_q <= 2'h3;
    err_all <= 1'h1;
    drive_ready_in <= 1'h1;
    cb_unit_in <= 2'h2;
    cb_last_in <= 1'h1;
    block(CB_WRITE_VERIFY, 16'h0);
    check("write", exec_write_out, 1'h1);
    check("error word", cb_err, 16'hd8e2);
    check("unit word", cb_unit, 16'h0084);
    check("status word", cb_stat, 16'h8074);
    check("done last", ord_ok, 1'h1);
    check("code", completion_status_out[15:6], CODE_SOFT);
    ack();
    wait_q <= 2'h0;
    err_all <= 1'h0;
    $display("test block execution done");
  endtask
  task automatic t_blk(input logic [3:0] cmd, input logic [15:0] entry,
                       input logic page, input logic [15:0] st,
                       input logic [9:0] code);
    pio(PIO_START, 1'h0);
    cb_bad_page_in <= page;
    block(cmd, entry);
    check("block status", cb_stat, st);
    check("block code", completion_status_out[15:6], code);
    ack();
    $display("test block command %0d done", cmd);
  endtask
  task automatic t_fail();
    pio(PIO_START, 1'h0);
    mem_error_in <= 1'h1;
    block(CB_READ_VERIFY, 16'h0);
    check("code", completion_status_out[15:6], CODE_UNWRITABLE);
    check("list stop", command_status_out[CS_LIST], 1'h0);
    ack();
    mem_error_in <= 1'h0;
    pio(PIO_START, 1'h0);
    cb_unreadable_in <= 1'h1;
    block(CB_READ, 16'h0);
    check("code", completion_status_out[15:6], CODE_UNREADABLE);
    ack();
    cb_unreadable_in <= 1'h0;
    $display("test failed blocks done");
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    t_pio();
    t_exec();
    t_blk(CB_READ_RAW, 16'h1, 1'h1, 16'h8002, CODE_NOT_ZERO);
    t_blk(CB_READ_RAW, 16'h0, 1'h0, 16'h8002, CODE_ILLEGAL);
    t_blk(CB_READ_HEADERS, 16'h0, 1'h1, 16'h8002, CODE_ILLEGAL);
    t_blk(CB_READ, 16'h0, 1'h1, 16'h8002, CODE_BAD_PAGE);
    t_blk(CB_READ_VERIFY, 16'h0, 1'h0, 16'h8000, CODE_CLEAN);
    t_blk(CB_WRITE_VER_SW, 16'h0, 1'h0, 16'h8000, CODE_CLEAN);
    t_fail();
    results();
  end
endmodule
`default_nettype wire
